// [octal_registered_bus_transceiver_bench.sv]
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module octal_registered_bus_transceiver_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import xcvr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        enable_n, direction, a_sel, b_sel, cap_a, cap_b, a_oe, b_oe, err, inv;
  byte_type    a_drive, b_drive, a_in, b_in, a_out, b_out, a_store, b_store;
  int          num_errors, n_tests, seed, r;

  registered_transceiver uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enable_n(enable_n), .direction(direction),
    .a_port_source_select(a_sel), .b_port_source_select(b_sel),
    .a_side_capture_clock(cap_a), .b_side_capture_clock(cap_b), .a_bus_in(a_in),
    .a_bus_out(a_out), .a_bus_oe(a_oe), .b_bus_in(b_in), .b_bus_out(b_out), .b_bus_oe(b_oe));
  xcvr_far_side far (.a_bus_oe(a_oe), .a_bus_out(a_out), .b_bus_oe(b_oe), .b_bus_out(b_out),
    .a_drive(a_drive), .b_drive(b_drive), .a_bus_in(a_in), .b_bus_in(b_in));

  always #12.5 pclk = ~pclk;

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic byte_type drv(logic sel, byte_type live, byte_type kept);
    return (sel ? kept : live) ^ {8{inv}};
  endfunction : drv

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    logic en, dr, sa, sb, ca, cb;
    byte_type av, bv, ab, bb;
    seed = 32'h61F118DE;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {enable_n, direction, a_sel, b_sel, cap_a, cap_b, inv} = 7'h40;
    {a_drive, b_drive} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b1, 12'h010, 32'h1);
    `CHK("unmapped err", 1'b1, err)
    for (int v = 0; v < 2; v++) begin
      inv = v[0];
      // live B onto A before the write, so the new polarity shows on a live path
      @(posedge pclk);
      {enable_n, direction, a_sel} <= 3'h0;
      repeat (4) @(posedge pclk);
      apb(1'b1, 12'h000, {31'h0, inv});
      repeat (4) @(posedge pclk);
      `CHK("steer", b_drive ^ {8{inv}}, a_out)
      for (int i = 0; i < 30; i++) begin
        r = $random(seed);
        {en, dr, sa, sb, ca, cb} = r[5:0];
        av = r[15:8];
        bv = r[23:16];
        if (i == 0) {en, ca, cb} = 3'h7;
        // a drive pass whose loop index is a multiple of three also captures the driven bus, which then holds the block's value
        if (!en && !dr) ca = (i % 3 == 0);
        if (!en && dr) cb = (i % 3 == 0);
        @(posedge pclk);
        {enable_n, direction, a_sel, b_sel} <= {en, dr, sa, sb};
        a_drive <= av;
        b_drive <= bv;
        // a bus the block has just taken over settles only after two passes through the sync
        repeat (6) @(posedge pclk);
        cap_a <= ca;
        cap_b <= cb;
        repeat (4) @(posedge pclk);
        {cap_a, cap_b} <= 2'h0;
        ab = (!en && !dr) ? drv(sa, bv, b_store) : av;
        bb = (!en && dr) ? drv(sb, av, a_store) : bv;
        if (ca) a_store = ab;
        if (cb) b_store = bb;
        repeat (4) @(posedge pclk);
        `CHK("a oe", !en && !dr, a_oe)
        `CHK("b oe", !en && dr, b_oe)
        if (!en && !dr) `CHK("a out", drv(sa, bv, b_store), a_out)
        if (!en && dr) `CHK("b out", drv(sb, av, a_store), b_out)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("status", {14'h0, !en && dr, !en && !dr, b_store, a_store}, rd)
      end
      $display("pass with invert %0d finished", v);
    end
    wrap_up();
  end
endmodule : octal_registered_bus_transceiver_bench

// [registered_transceiver.sv]
`include "xcvr_cfg.svh"
module registered_transceiver (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              enable_n,
  input  wire logic              direction,
  input  wire logic              a_port_source_select,
  input  wire logic              b_port_source_select,
  input  wire logic              a_side_capture_clock,
  input  wire logic              b_side_capture_clock,
  input  wire xcvr_pkg::byte_type a_bus_in,
  output xcvr_pkg::byte_type     a_bus_out,
  output logic                   a_bus_oe,
  input  wire xcvr_pkg::byte_type b_bus_in,
  output xcvr_pkg::byte_type     b_bus_out,
  output logic                   b_bus_oe
);
  import xcvr_pkg::*;

  logic [`PIN_SYNC_WIDTH-1:0] meta_q;
  logic [`PIN_SYNC_WIDTH-1:0] sync_q;
  logic                       cab_prev_q;
  logic                       cba_prev_q;
  logic                       invert_q;
  byte_type                   a_store_q;
  byte_type                   b_store_q;
  byte_type                   a_out_q;
  byte_type                   b_out_q;
  logic                       a_oe_q;
  logic                       b_oe_q;
  logic [31:0]                prdata_q;
  logic                       pready_q;
  logic                       pslverr_q;
  drive_mode_type             mode_d;
  byte_type                   inv_mask;
  logic                       en_n_s;
  logic                       dir_s;
  logic                       asel_s;
  logic                       bsel_s;
  logic                       cab_s;
  logic                       cba_s;
  byte_type                   a_in_s;
  byte_type                   b_in_s;
  logic                       cab_rise;
  logic                       cba_rise;
  logic                       apb_access;
  logic                       hit_ctrl;
  logic                       hit_status;
  logic                       a_loaded_q;
  logic                       b_loaded_q;
  byte_type                   a_out_d;
  byte_type                   b_out_d;

  // every pin is asynchronous to pclk, so the whole group goes through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= `PIN_SYNC_RESET;
      sync_q <= `PIN_SYNC_RESET;
    end else begin
      meta_q <= {enable_n, direction, a_port_source_select, b_port_source_select,
                 a_side_capture_clock, b_side_capture_clock, a_bus_in, b_bus_in};
      sync_q <= meta_q;
    end
  end

  assign {en_n_s, dir_s, asel_s, bsel_s, cab_s, cba_s, a_in_s, b_in_s} = sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cab_prev_q <= 1'b0;
      cba_prev_q <= 1'b0;
    end else begin
      cab_prev_q <= cab_s;
      cba_prev_q <= cba_s;
    end
  end

  // data and clock share the same sync delay, so the sampled bus lines up with the edge
  assign cab_rise = cab_s && !cab_prev_q;
  assign cba_rise = cba_s && !cba_prev_q;

  // no reset here: stored words stay undefined until the first capture
  always_ff @(posedge pclk) begin
    if (cab_rise) begin
      a_store_q <= a_in_s;
    end
  end

  always_ff @(posedge pclk) begin
    if (cba_rise) begin
      b_store_q <= b_in_s;
    end
  end

  // the stores have no reset, so these flags tell the checks when a stored word is defined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_loaded_q <= 1'b0;
    end else if (cab_rise) begin
      a_loaded_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_loaded_q <= 1'b0;
    end else if (cba_rise) begin
      b_loaded_q <= 1'b1;
    end
  end

  assign inv_mask = {`XCVR_WIDTH{invert_q}};

  // each bit is steered and polarised on its own, so no bit can leak into a neighbour
  for (genvar bit_idx = 0; bit_idx < `XCVR_WIDTH; bit_idx = bit_idx + 1) begin : g_bit
    assign a_out_d[bit_idx] = (asel_s ? b_store_q[bit_idx] : b_in_s[bit_idx])
                              ^ inv_mask[bit_idx];
    assign b_out_d[bit_idx] = (bsel_s ? a_store_q[bit_idx] : a_in_s[bit_idx])
                              ^ inv_mask[bit_idx];
    a_bit_a_live: assert property (@(posedge pclk) disable iff (!presetn)
      !en_n_s && !dir_s && !asel_s |=> a_out_q[bit_idx]
        == ($past(b_in_s[bit_idx]) ^ $past(invert_q)))
      else $error("A bus bit not driven from its own B bit");
    a_bit_b_live: assert property (@(posedge pclk) disable iff (!presetn)
      !en_n_s && dir_s && !bsel_s |=> b_out_q[bit_idx]
        == ($past(a_in_s[bit_idx]) ^ $past(invert_q)))
      else $error("B bus bit not driven from its own A bit");
  end

  always_comb begin
    mode_d = MODE_ISOLATE;
    if (!en_n_s) begin
      mode_d = dir_s ? MODE_DRIVE_B : MODE_DRIVE_A;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_oe_q  <= 1'b0;
      b_oe_q  <= 1'b0;
      a_out_q <= '0;
      b_out_q <= '0;
    end else begin
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
      unique case (mode_d)
        MODE_ISOLATE: begin
          a_out_q <= a_out_q;
          b_out_q <= b_out_q;
        end
        MODE_DRIVE_A: begin
          a_oe_q  <= 1'b1;
          a_out_q <= a_out_d;
        end
        MODE_DRIVE_B: begin
          b_oe_q  <= 1'b1;
          b_out_q <= b_out_d;
        end
      endcase
    end
  end

  assign a_bus_out = a_out_q;
  assign b_bus_out = b_out_q;
  assign a_bus_oe  = a_oe_q;
  assign b_bus_oe  = b_oe_q;

  // apb slave: one wait state keeps pready a flop output
  assign apb_access = psel && penable && !pready_q;
  assign hit_ctrl   = (paddr == `CTRL_OFFSET);
  assign hit_status = (paddr == `STATUS_OFFSET);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invert_q <= `CTRL_RESET;
    end else if (apb_access && pwrite && hit_ctrl) begin
      invert_q <= pwdata[`CTRL_INVERT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= apb_access;
      pslverr_q <= apb_access && !(hit_ctrl || hit_status);
      prdata_q  <= '0;
      if (apb_access && !pwrite && hit_ctrl) begin
        prdata_q[`CTRL_INVERT_BIT] <= invert_q;
      end else if (apb_access && !pwrite && hit_status) begin
        prdata_q[`STAT_A_STORE_LSB +: `XCVR_WIDTH] <= a_store_q;
        prdata_q[`STAT_B_STORE_LSB +: `XCVR_WIDTH] <= b_store_q;
        prdata_q[`STAT_A_OE_BIT] <= a_oe_q;
        prdata_q[`STAT_B_OE_BIT] <= b_oe_q;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  sequence drive_a_live_seq;
    !en_n_s && !dir_s && !asel_s;
  endsequence

  sequence drive_a_stored_seq;
    !en_n_s && !dir_s && asel_s;
  endsequence

  sequence drive_b_live_seq;
    !en_n_s && dir_s && !bsel_s;
  endsequence

  sequence drive_b_stored_seq;
    !en_n_s && dir_s && bsel_s;
  endsequence

  sequence ctrl_write_seq;
    apb_access && pwrite && hit_ctrl;
  endsequence

  sequence drive_a_seq;
    !en_n_s && !dir_s;
  endsequence

  sequence drive_b_seq;
    !en_n_s && dir_s;
  endsequence

  sequence isolate_seq;
    en_n_s;
  endsequence

  a_one_bus_only: assert property (@(posedge pclk) disable iff (!presetn)
    !(a_oe_q && b_oe_q)) else $error("both buses driven at once");

  a_a_capture_only: assert property (@(posedge pclk) disable iff (!presetn)
    cab_rise && !cba_rise |=> a_store_q == $past(a_in_s)
      && (!b_loaded_q || $stable(b_store_q)))
    else $error("A capture edge did not load A register alone");

  a_b_capture_only: assert property (@(posedge pclk) disable iff (!presetn)
    cba_rise && !cab_rise |=> b_store_q == $past(b_in_s)
      && (!a_loaded_q || $stable(a_store_q)))
    else $error("B capture edge did not load B register alone");

  a_capture_while_drive: assert property (@(posedge pclk) disable iff (!presetn)
    cab_rise && cba_rise && !en_n_s |=> a_store_q == $past(a_in_s)
      && b_store_q == $past(b_in_s)) else $error("capture blocked while driving");

  a_isolate_hold: assert property (@(posedge pclk) disable iff (!presetn)
    en_n_s && !cab_rise && !cba_rise |=> !a_oe_q && !b_oe_q
      && (!a_loaded_q || $stable(a_store_q)) && (!b_loaded_q || $stable(b_store_q)))
    else $error("isolation not held");

  a_a_live_path: assert property (@(posedge pclk) disable iff (!presetn)
    drive_a_live_seq |=> a_oe_q && !b_oe_q
      && a_out_q == ($past(b_in_s) ^ {8{$past(invert_q)}}))
    else $error("A bus not driven with live B data");

  a_a_stored_path: assert property (@(posedge pclk) disable iff (!presetn)
    drive_a_stored_seq |=> a_oe_q && a_out_q == ($past(b_store_q) ^ {8{$past(invert_q)}}))
    else $error("A bus not driven with stored B word");

  a_b_live_path: assert property (@(posedge pclk) disable iff (!presetn)
    drive_b_live_seq |=> b_oe_q && !a_oe_q
      && b_out_q == ($past(a_in_s) ^ {8{$past(invert_q)}}))
    else $error("B bus not driven with live A data");

  a_b_stored_path: assert property (@(posedge pclk) disable iff (!presetn)
    drive_b_stored_seq |=> b_oe_q && b_out_q == ($past(a_store_q) ^ {8{$past(invert_q)}}))
    else $error("B bus not driven with stored A word");

  a_invert_steer: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_write_seq ##1 drive_a_live_seq |=> a_out_q == ($past(b_in_s)
      ^ {8{$past(pwdata[`CTRL_INVERT_BIT], 2)}}))
    else $error("invert control did not steer data path");

  a_pin_to_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_n && direction ##1 (!enable_n && direction) [*2] |=> b_oe_q && !a_oe_q)
    else $error("direction did not select B bus within three edges");

  a_a_capture_any: assert property (@(posedge pclk) disable iff (!presetn)
    cab_rise |=> a_store_q == $past(a_in_s)) else $error("A capture edge not stored");

  a_b_capture_any: assert property (@(posedge pclk) disable iff (!presetn)
    cba_rise |=> b_store_q == $past(b_in_s)) else $error("B capture edge not stored");

  a_isolate_both_load: assert property (@(posedge pclk) disable iff (!presetn)
    isolate_seq ##0 (cab_rise && cba_rise) |=> a_store_q == $past(a_in_s)
      && b_store_q == $past(b_in_s))
    else $error("isolated buses not both stored");

  a_isolate_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    isolate_seq |=> !a_oe_q && !b_oe_q
      && $stable(a_out_q) && $stable(b_out_q))
    else $error("a bus driven or changed while isolated");

  a_direction_choice: assert property (@(posedge pclk) disable iff (!presetn)
    !en_n_s |=> (a_oe_q != b_oe_q) && (b_oe_q == $past(dir_s)))
    else $error("direction did not pick exactly one bus");

  a_capture_idle_b: assert property (@(posedge pclk) disable iff (!presetn)
    drive_a_seq ##0 cba_rise |=> b_store_q == $past(b_in_s))
    else $error("undriven B bus not captured while driving A");

  a_capture_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    drive_b_seq ##0 cab_rise |=> a_store_q == $past(a_in_s))
    else $error("undriven A bus not captured while driving B");

  a_invert_load: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_write_seq |=> invert_q == $past(pwdata[`CTRL_INVERT_BIT]))
    else $error("variant select not loaded by control write");

  a_pin_to_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_n && !direction ##1 (!enable_n && !direction) [*2] |=> a_oe_q && !b_oe_q)
    else $error("direction did not select A bus within three edges");

  a_pin_to_isolate: assert property (@(posedge pclk) disable iff (!presetn)
    enable_n ##1 enable_n [*2] |=> !a_oe_q && !b_oe_q)
    else $error("enable high did not isolate within three edges");

  // register bus handshake: one wait state, one-cycle answer
  a_apb_wait_state: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access |=> pready_q) else $error("access not answered after one wait state");

  a_apb_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q |=> !pready_q) else $error("ready stood longer than one cycle");

  a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    apb_access && !(hit_ctrl || hit_status) |=> pslverr_q && prdata_q == '0)
    else $error("unmapped access not refused");

endmodule : registered_transceiver

// [xcvr_cfg.svh]
`ifndef XCVR_CFG_SVH
`define XCVR_CFG_SVH

`define XCVR_WIDTH        8
`define APB_ADDR_WIDTH    12
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define CTRL_INVERT_BIT   0
`define CTRL_RESET        1'b0
`define STAT_A_STORE_LSB  0
`define STAT_B_STORE_LSB  8
`define STAT_A_OE_BIT     16
`define STAT_B_OE_BIT     17
`define PIN_SYNC_WIDTH    22
`define PIN_SYNC_RESET    22'h20_0000
`endif

// [xcvr_far_side.sv]
module xcvr_far_side (
  input  wire logic               a_bus_oe,
  input  wire xcvr_pkg::byte_type a_bus_out,
  input  wire logic               b_bus_oe,
  input  wire xcvr_pkg::byte_type b_bus_out,
  input  wire xcvr_pkg::byte_type a_drive,
  input  wire xcvr_pkg::byte_type b_drive,
  output xcvr_pkg::byte_type      a_bus_in,
  output xcvr_pkg::byte_type      b_bus_in
);
  import xcvr_pkg::*;
  // far logic lets go of a bus the block drives, so the wire carries the block's value
  assign a_bus_in = a_bus_oe ? a_bus_out : a_drive;
  assign b_bus_in = b_bus_oe ? b_bus_out : b_drive;
endmodule : xcvr_far_side

// [xcvr_pkg.sv]
package xcvr_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [1:0] {
    MODE_ISOLATE,
    MODE_DRIVE_A,
    MODE_DRIVE_B
  } drive_mode_type;
endpackage : xcvr_pkg
